// ===== core/clk_ctrl_pkg.sv
// Package with register map, field layout, timing and types of the clock-control block
package clk_ctrl_pkg;
  // Timing
  localparam int CLK_FREQ_MHZ = 50;
  localparam int STOP_DETECT_NS = 1000;
  localparam int STOP_DETECT_CYC = (STOP_DETECT_NS * CLK_FREQ_MHZ + 999) / 1000;

  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_LS_OSC_CTRL = 6'h07;
  localparam logic [5:0] IDX_WAIT_CTRL = 6'h09;
  localparam logic [5:0] IDX_OSC_STOP = 6'h0c;
  localparam logic [5:0] IDX_CORR_32MHZ = 6'h15;
  localparam logic [5:0] IDX_HS_OSC_CTRL = 6'h23;
  localparam logic [5:0] IDX_WRITE_PROTECT = 6'h30;

  // Field positions
  localparam int DET_EN_BIT = 0;
  localparam int DET_IRQ_EN_BIT = 1;
  localparam int SYS_CLK_SEL_BIT = 2;
  localparam int HS_EN_BIT = 0;
  localparam int HS_SEL_BIT = 1;
  localparam int HS_RSV_BIT = 2;
  localparam int DIV128_SEL_BIT = 3;
  localparam int LS_STOP_BIT = 4;
  localparam int WAIT_BIT = 0;
  localparam int UNLOCK_BIT = 0;

  // Reset values
  localparam logic [7:0] OSC_STOP_RST = 8'h04;
  localparam logic [7:0] HS_OSC_CTRL_RST = 8'h00;
  localparam logic [7:0] CORR_32MHZ_DEFAULT = 8'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic clock_monitor;
    logic system_clock_select;
    logic stop_detect_irq_enable;
    logic stop_detect_enable;
  } osc_stop_s;

  typedef struct packed {
    logic div128_source_select;
    logic reserved;
    logic hs_osc_select;
    logic hs_osc_enable;
  } hs_ctrl_s;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_WAIT = 2'b10
  } wait_state_e;
endpackage

// ===== core/osc_stop_detector.sv
// Crystal oscillation-stop detector: flags a stop when no activity is seen for a timeout
`timescale 1ns/1ps
module osc_stop_detector #(
  parameter int TIMEOUT_CYC = 50
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic enable_in,
  input wire logic activity_in,
  output logic stopped_out
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);

  if (TIMEOUT_CYC < 1) begin : g_chk
    $error("TIMEOUT_CYC must be at least 1");
  end

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic stopped_ff;
  logic nxt_stopped;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_stopped = stopped_ff;
    if (!enable_in || activity_in) begin
      nxt_cnt = '0;
      nxt_stopped = 1'b0;
    end else if (cnt_ff == CW'(TIMEOUT_CYC)) begin
      nxt_stopped = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + CW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_ff <= '0;
      stopped_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      stopped_ff <= nxt_stopped;
    end
  end

  assign stopped_out = stopped_ff;
endmodule

// ===== core/clk_ctrl_top.sv
// Wait mode, oscillation-stop detection and on-chip oscillator control with AXI4-Lite registers
//
// Contract
// - Writing 1 to the wait bit stops the CPU clock, entering wait mode; the code takes that write only with the write-unlock bit at 1.
// - Crystal, sub and on-chip oscillator clocks keep running during wait mode.
// - Wait mode ends only by reset or a peripheral interrupt request.
// - Waking with interrupts masked resumes after the wait write, no servicing.
// - Stop register bit 0 enables detection, bit 1 enables its interrupt.
// - Bit 2 selects system clock: 0 crystal, 1 on-chip; resets to 1.
// - Bit 3 read-only monitor: 0 crystal oscillating, 1 crystal stopped.
// - System clock select at 1 forces the low-speed stop bit to 0.
// - Stop detected with both enables set forces system clock select to 1.
// - While monitor reads 1, writing 0 to system clock select is ignored.
// - Monitor is valid only with detection enabled, else stays 0.
// - Stop and high-speed control writes need the write-unlock bit at 1.
// - Read-only 8-bit register holds the factory 32 MHz correction value.
// - High-speed control bit 0 turns oscillator on, bit 1 selects it.
// - Bit 3 picks slow or fast on-chip clock for the divide-by-128 clock.
// - Unassigned upper high-speed control bits read 0 and ignore writes.
// - Low-speed stop bit 0 runs the low-speed oscillator, 1 stops it.
// - A peripheral-interrupt wakeup clears the wait bit by hardware.
`timescale 1ns/1ps
module clk_ctrl_top
  import clk_ctrl_pkg::*;
#(
  parameter logic [7:0] CORR_32MHZ_VALUE = CORR_32MHZ_DEFAULT,
  parameter int STOP_TIMEOUT_CYC = STOP_DETECT_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  // AXI4-Lite write channels
  input wire logic [7:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  // AXI4-Lite read channels
  input wire logic [7:0] AXI_ARADDR_IN,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  // CPU and interrupt side
  input wire logic CPU_IFLAG_IN,
  input wire logic PERIPH_IRQ_IN,
  input wire logic STOP_IRQ_ACK_IN,
  output logic CPU_CLK_EN_OUT,
  output logic WAKE_SERVICE_OUT,
  output logic WAKE_RESUME_OUT,
  output logic STOP_IRQ_OUT,
  // Oscillator side
  input wire logic XTAL_ACTIVITY_IN,
  output logic SYS_CLK_SEL_OUT,
  output logic LS_OSC_ON_OUT,
  output logic HS_OSC_ON_OUT,
  output logic HS_OSC_SEL_OUT,
  output logic DIV128_SEL_OUT
);
  // Bus slave state
  logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic [5:0] aw_idx_ff, nxt_aw_idx;
  logic [7:0] wdata_ff, nxt_wdata;
  logic wstrb_ff, nxt_wstrb;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [7:0] rdata_ff, nxt_rdata;
  logic wr_fire, wr_ok, wr_mapped, rd_mapped;
  logic [7:0] rd_val;
  logic [5:0] rd_idx;

  // Control registers
  osc_stop_s ocd_ff, nxt_ocd;
  hs_ctrl_s hs_ff, nxt_hs;
  logic ls_stop_ff, nxt_ls_stop, unlock_ff, nxt_unlock, irq_ff, nxt_irq;
  logic stop_flag, stop_rise;

  // Wait control
  wait_state_e state_ff, nxt_state;
  logic wait_bit_ff, nxt_wait_bit, iflag_ff, nxt_iflag;
  logic service_ff, nxt_service, resume_ff, nxt_resume, cpu_en_ff, nxt_cpu_en;

  osc_stop_detector #(
    .TIMEOUT_CYC(STOP_TIMEOUT_CYC)
  ) u_det (
    .clk_in(CLK_SYS_IN),
    .rst_b_in(RST_B_IN),
    .enable_in(ocd_ff.stop_detect_enable),
    .activity_in(XTAL_ACTIVITY_IN),
    .stopped_out(stop_flag)
  );

  assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_ok = wr_fire && wstrb_ff;
  assign rd_idx = AXI_ARADDR_IN[7:2];
  assign stop_rise = stop_flag && !ocd_ff.clock_monitor;

  always_comb begin
    wr_mapped = (aw_idx_ff == IDX_LS_OSC_CTRL) || (aw_idx_ff == IDX_WAIT_CTRL) || (aw_idx_ff == IDX_OSC_STOP) ||
      (aw_idx_ff == IDX_CORR_32MHZ) || (aw_idx_ff == IDX_HS_OSC_CTRL) || (aw_idx_ff == IDX_WRITE_PROTECT);
    rd_mapped = 1'b1;
    case (rd_idx)
      IDX_LS_OSC_CTRL: rd_val = 8'(ls_stop_ff) << LS_STOP_BIT;
      IDX_WAIT_CTRL: rd_val = {7'h00, wait_bit_ff};
      IDX_OSC_STOP: rd_val = {4'h0, ocd_ff};
      IDX_CORR_32MHZ: rd_val = CORR_32MHZ_VALUE;
      IDX_HS_OSC_CTRL: rd_val = {4'h0, hs_ff};
      IDX_WRITE_PROTECT: rd_val = {7'h00, unlock_ff};
      default: begin
        rd_val = 8'h00;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // Bus slave: address and data taken in either order, response after both
  always_comb begin
    nxt_aw_have = aw_have_ff;
    nxt_w_have = w_have_ff;
    nxt_aw_idx = aw_idx_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (AXI_AWVALID_IN && awready_ff) begin
      nxt_aw_have = 1'b1;
      nxt_aw_idx = AXI_AWADDR_IN[7:2];
    end
    if (AXI_WVALID_IN && wready_ff) begin
      nxt_w_have = 1'b1;
      nxt_wdata = AXI_WDATA_IN[7:0];
      nxt_wstrb = AXI_WSTRB_IN[0];
    end
    if (wr_fire) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && AXI_BREADY_IN) begin
      nxt_bvalid = 1'b0;
    end
    if (AXI_ARVALID_IN && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = rd_val;
      nxt_rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && AXI_RREADY_IN) begin
      nxt_rvalid = 1'b0;
    end
    nxt_awready = !nxt_aw_have && !nxt_bvalid;
    nxt_wready = !nxt_w_have && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_idx_ff <= 6'h00;
      wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 8'h00;
    end else begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      aw_idx_ff <= nxt_aw_idx;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // Clock-control registers
  always_comb begin
    nxt_ocd = ocd_ff;
    nxt_hs = hs_ff;
    nxt_ls_stop = ls_stop_ff;
    nxt_unlock = unlock_ff;
    nxt_irq = irq_ff;
    if (wr_ok && aw_idx_ff == IDX_WRITE_PROTECT) begin
      nxt_unlock = wdata_ff[UNLOCK_BIT];
    end
    if (wr_ok && unlock_ff) begin
      if (aw_idx_ff == IDX_OSC_STOP) begin
        nxt_ocd.stop_detect_enable = wdata_ff[DET_EN_BIT];
        nxt_ocd.stop_detect_irq_enable = wdata_ff[DET_IRQ_EN_BIT];
        if (wdata_ff[SYS_CLK_SEL_BIT] || !ocd_ff.clock_monitor) begin
          nxt_ocd.system_clock_select = wdata_ff[SYS_CLK_SEL_BIT];
        end
      end
      if (aw_idx_ff == IDX_HS_OSC_CTRL) begin
        nxt_hs.hs_osc_enable = wdata_ff[HS_EN_BIT];
        nxt_hs.hs_osc_select = wdata_ff[HS_SEL_BIT];
        nxt_hs.reserved = wdata_ff[HS_RSV_BIT];
        nxt_hs.div128_source_select = wdata_ff[DIV128_SEL_BIT];
      end
      if (aw_idx_ff == IDX_LS_OSC_CTRL) begin
        nxt_ls_stop = wdata_ff[LS_STOP_BIT];
      end
    end
    // Monitor follows the detector, which idles while detection is off
    nxt_ocd.clock_monitor = stop_flag;
    if (stop_rise && ocd_ff.stop_detect_enable && ocd_ff.stop_detect_irq_enable) begin
      nxt_ocd.system_clock_select = 1'b1;
    end
    if (nxt_ocd.system_clock_select) begin
      nxt_ls_stop = 1'b0;
    end
    if (STOP_IRQ_ACK_IN) begin
      nxt_irq = 1'b0;
    end
    if (stop_rise && ocd_ff.stop_detect_irq_enable) begin
      nxt_irq = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ocd_ff <= osc_stop_s'(OSC_STOP_RST[3:0]);
      hs_ff <= hs_ctrl_s'(HS_OSC_CTRL_RST[3:0]);
      ls_stop_ff <= 1'b0;
      unlock_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      ocd_ff <= nxt_ocd;
      hs_ff <= nxt_hs;
      ls_stop_ff <= nxt_ls_stop;
      unlock_ff <= nxt_unlock;
      irq_ff <= nxt_irq;
    end
  end

  // Wait mode sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_wait_bit = wait_bit_ff;
    nxt_iflag = iflag_ff;
    nxt_service = 1'b0;
    nxt_resume = 1'b0;
    if (wr_ok && unlock_ff && aw_idx_ff == IDX_WAIT_CTRL && wdata_ff[WAIT_BIT]) begin
      nxt_wait_bit = 1'b1;
    end
    case (state_ff)
      ST_RUN: begin
        if (wait_bit_ff) begin
          nxt_state = ST_WAIT;
          nxt_iflag = CPU_IFLAG_IN;
        end
      end
      ST_WAIT: begin
        if (PERIPH_IRQ_IN) begin
          nxt_state = ST_RUN;
          nxt_wait_bit = 1'b0;
          nxt_service = iflag_ff;
          nxt_resume = !iflag_ff;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
    nxt_cpu_en = (nxt_state == ST_RUN);
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_ff <= ST_RUN;
      wait_bit_ff <= 1'b0;
      iflag_ff <= 1'b0;
      service_ff <= 1'b0;
      resume_ff <= 1'b0;
      cpu_en_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      wait_bit_ff <= nxt_wait_bit;
      iflag_ff <= nxt_iflag;
      service_ff <= nxt_service;
      resume_ff <= nxt_resume;
      cpu_en_ff <= nxt_cpu_en;
    end
  end

  assign AXI_AWREADY_OUT = awready_ff;
  assign AXI_WREADY_OUT = wready_ff;
  assign AXI_BVALID_OUT = bvalid_ff;
  assign AXI_BRESP_OUT = bresp_ff;
  assign AXI_ARREADY_OUT = arready_ff;
  assign AXI_RVALID_OUT = rvalid_ff;
  assign AXI_RRESP_OUT = rresp_ff;
  assign AXI_RDATA_OUT = {24'h000000, rdata_ff};
  assign CPU_CLK_EN_OUT = cpu_en_ff;
  assign WAKE_SERVICE_OUT = service_ff;
  assign WAKE_RESUME_OUT = resume_ff;
  assign STOP_IRQ_OUT = irq_ff;
  // Oscillator enables do not depend on wait mode
  assign SYS_CLK_SEL_OUT = ocd_ff.system_clock_select;
  assign HS_OSC_ON_OUT = hs_ff.hs_osc_enable;
  assign HS_OSC_SEL_OUT = hs_ff.hs_osc_select;
  assign DIV128_SEL_OUT = hs_ff.div128_source_select;
  assign LS_OSC_ON_OUT = !ls_stop_ff;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);

  chk_wait_entry_clk: assert property (state_ff == ST_RUN && wait_bit_ff |=> !CPU_CLK_EN_OUT)
    else $error("CPU clock still enabled after wait entry");
  chk_wait_holds: assert property (state_ff == ST_WAIT && !PERIPH_IRQ_IN |=> state_ff == ST_WAIT && !CPU_CLK_EN_OUT)
    else $error("Wait mode left without interrupt");
  chk_wake_clear_bit: assert property (state_ff == ST_WAIT && PERIPH_IRQ_IN |=> !wait_bit_ff && CPU_CLK_EN_OUT)
    else $error("Wakeup did not clear wait bit");
  chk_masked_resume: assert property (state_ff == ST_WAIT && PERIPH_IRQ_IN && !iflag_ff |=> WAKE_RESUME_OUT && !WAKE_SERVICE_OUT)
    else $error("Masked wakeup not resumed");
  chk_sel_forces_ls: assert property (ocd_ff.system_clock_select |-> LS_OSC_ON_OUT)
    else $error("Low-speed oscillator off while on-chip clock selected");
  chk_monitor_keeps_sel: assert property (ocd_ff.clock_monitor && ocd_ff.system_clock_select |=> ocd_ff.system_clock_select)
    else $error("System clock select cleared while crystal stopped");
  chk_stop_fallback: assert property (stop_rise && ocd_ff.stop_detect_enable && ocd_ff.stop_detect_irq_enable
    |=> ocd_ff.system_clock_select && ocd_ff.clock_monitor)
    else $error("No fallback after stop detection");
  chk_monitor_off_idle: assert property (!ocd_ff.stop_detect_enable [*2] |=> !ocd_ff.clock_monitor)
    else $error("Monitor set with detection disabled");
  chk_locked_hs_write: assert property (wr_ok && !unlock_ff && aw_idx_ff == IDX_HS_OSC_CTRL |=> $stable(hs_ff))
    else $error("Locked write changed oscillator control");
  chk_irq_held: assert property (STOP_IRQ_OUT && !STOP_IRQ_ACK_IN |=> STOP_IRQ_OUT)
    else $error("Stop interrupt dropped before acknowledge");

  cov_wait_wake: cover property (state_ff == ST_WAIT && PERIPH_IRQ_IN ##1 WAKE_SERVICE_OUT);
  cov_stop_fallback: cover property (stop_rise && ocd_ff.stop_detect_irq_enable ##1 STOP_IRQ_OUT);
  cov_hs_write: cover property (wr_ok && unlock_ff && aw_idx_ff == IDX_HS_OSC_CTRL);
endmodule

// ===== sim/clk_ctrl_top_test.sv
// Self-checking testbench for the clock-control block over its register bus and side ports
`timescale 1ns/1ps
module clk_ctrl_top_test;
  import clk_ctrl_pkg::*;
  localparam int STO = 4;
  // Arbitrary stand-in for the factory correction value
  localparam logic [7:0] CORR = 8'h5a;
  logic clk, rst_b, awv, wv, br, arv, rr, ifl, pirq, ack, xact;
  logic awr, wr_rdy, bv, arr, rv, cen, wsv, wrs, sirq, ssel, lson, hson, hssel, d128;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd_d;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, r;
  logic [7:0] d;
  int mismatches, n_checks;

  clk_ctrl_top #(.CORR_32MHZ_VALUE(CORR), .STOP_TIMEOUT_CYC(STO)) u_clk_ctrl_top (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr),
    .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(ws), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wr_rdy), .AXI_BRESP_OUT(bresp),
    .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(br), .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
    .AXI_RDATA_OUT(rd_d), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rr),
    .CPU_IFLAG_IN(ifl), .PERIPH_IRQ_IN(pirq), .STOP_IRQ_ACK_IN(ack), .CPU_CLK_EN_OUT(cen),
    .WAKE_SERVICE_OUT(wsv), .WAKE_RESUME_OUT(wrs), .STOP_IRQ_OUT(sirq), .XTAL_ACTIVITY_IN(xact),
    .SYS_CLK_SEL_OUT(ssel), .LS_OSC_ON_OUT(lson), .HS_OSC_ON_OUT(hson), .HS_OSC_SEL_OUT(hssel),
    .DIV128_SEL_OUT(d128));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("BAD %s exp %h seen %h", nm, exp, seen);
      mismatches++;
    end
  endtask

  task automatic tmo;
    $display("BAD bus_wait exp 1 seen 0");
    mismatches++;
    test_done();
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] v, output logic [1:0] resp);
    logic a, w;
    int n;
    a = 1'h0;
    w = 1'h0;
    n = 0;
    @(posedge clk);
    awa <= {idx, 2'h0};
    wd <= {24'h0, v};
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    while (!(a && w)) begin
      @(posedge clk);
      if (!a && awr === 1'h1) begin
        a = 1'h1;
        awv <= 1'h0;
      end
      if (!w && wr_rdy === 1'h1) begin
        w = 1'h1;
        wv <= 1'h0;
      end
      n++;
      if (n > 50) tmo();
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) tmo();
    end while (bv !== 1'h1);
    resp = bresp;
    br <= 1'h0;
  endtask

  task automatic rd(input logic [5:0] idx, output logic [7:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk);
    ara <= {idx, 2'h0};
    arv <= 1'h1;
    rr <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) tmo();
    end while (arr !== 1'h1);
    arv <= 1'h0;
    do begin
      @(posedge clk);
      n++;
      if (n > 100) tmo();
    end while (rv !== 1'h1);
    v = rd_d[7:0];
    check("rdata_upper", rd_d[31:8], 32'h0);
    resp = rresp;
    rr <= 1'h0;
  endtask

  task automatic wrk(input logic [5:0] idx, input logic [7:0] v);
    wr(idx, v, r);
    check("bresp", r, RESP_OKAY);
  endtask

  task automatic rdk(input string nm, input logic [5:0] idx, input logic [7:0] exp);
    rd(idx, d, r);
    check("rresp", r, RESP_OKAY);
    check(nm, d, exp);
  endtask

  task automatic t_reset;
    check("cpu_clk_en", cen, 1'h1);
    check("pins", {ssel, lson, hson, hssel, d128, sirq}, 6'h30);
    rdk("osc_stop_rst", IDX_OSC_STOP, 8'h04);
    rdk("hs_ctrl_rst", IDX_HS_OSC_CTRL, 8'h00);
    rdk("corr", IDX_CORR_32MHZ, CORR);
    $display("test reset done");
  endtask

  task automatic t_protect;
    wrk(IDX_HS_OSC_CTRL, 8'h0b);
    rdk("hs_locked", IDX_HS_OSC_CTRL, 8'h00);
    wrk(IDX_OSC_STOP, 8'h00);
    rdk("osc_locked", IDX_OSC_STOP, 8'h04);
    wrk(IDX_CORR_32MHZ, 8'ha5);
    rdk("corr_ro", IDX_CORR_32MHZ, CORR);
    rd(6'h3f, d, r);
    check("unmapped_rresp", r, RESP_SLVERR);
    check("unmapped_data", d, 8'h00);
    wr(6'h3f, 8'hff, r);
    check("unmapped_bresp", r, RESP_SLVERR);
    wrk(IDX_WRITE_PROTECT, 8'h01);
    $display("test protect done");
  endtask

  task automatic t_hs;
    // Oscillator on before its select bit is changed
    wrk(IDX_HS_OSC_CTRL, 8'h01);
    check("hs_on_first", {hson, hssel}, 2'h2);
    wrk(IDX_HS_OSC_CTRL, 8'hff);
    rdk("hs_upper", IDX_HS_OSC_CTRL, 8'h0f);
    check("hs_pins", {hson, hssel, d128}, 3'h7);
    // Select cleared before enable
    wrk(IDX_HS_OSC_CTRL, 8'h01);
    check("hs_sel_off", {hson, hssel, d128}, 3'h4);
    wrk(IDX_HS_OSC_CTRL, 8'h00);
    check("hs_off", {hson, hssel}, 2'h0);
    // Write with its low byte strobe cleared leaves the register alone
    ws <= 4'h0;
    wrk(IDX_HS_OSC_CTRL, 8'h01);
    rdk("hs_no_strobe", IDX_HS_OSC_CTRL, 8'h00);
    ws <= 4'hf;
    $display("test hs done");
  endtask

  task automatic t_sysclk;
    wrk(IDX_OSC_STOP, 8'h00);
    check("sel_xtal", ssel, 1'h0);
    wrk(IDX_LS_OSC_CTRL, 8'h10);
    check("ls_off", lson, 1'h0);
    wrk(IDX_OSC_STOP, 8'h04);
    check("ls_forced", {ssel, lson}, 2'h3);
    rdk("ls_bit", IDX_LS_OSC_CTRL, 8'h00);
    wrk(IDX_LS_OSC_CTRL, 8'h10);
    check("ls_held", lson, 1'h1);
    $display("test sysclk done");
  endtask

  task automatic t_stop;
    wrk(IDX_OSC_STOP, 8'h03);
    check("sel0", ssel, 1'h0);
    xact <= 1'h0;
    repeat (STO + 8) @(posedge clk);
    check("stop_irq", sirq, 1'h1);
    check("auto_sel", ssel, 1'h1);
    rdk("monitor_set", IDX_OSC_STOP, 8'h0f);
    wrk(IDX_OSC_STOP, 8'h03);
    rdk("sel_kept", IDX_OSC_STOP, 8'h0f);
    check("irq_held", sirq, 1'h1);
    ack <= 1'h1;
    @(posedge clk);
    ack <= 1'h0;
    @(posedge clk);
    #1 check("irq_acked", sirq, 1'h0);
    @(posedge clk);
    xact <= 1'h1;
    repeat (4) @(posedge clk);
    rdk("monitor_clr", IDX_OSC_STOP, 8'h07);
    // Both enables cleared before stopping the crystal
    wrk(IDX_OSC_STOP, 8'h00);
    xact <= 1'h0;
    repeat (STO + 8) @(posedge clk);
    rdk("monitor_off", IDX_OSC_STOP, 8'h00);
    check("no_irq", {sirq, ssel}, 2'h0);
    wrk(IDX_OSC_STOP, 8'h01);
    repeat (STO + 8) @(posedge clk);
    rdk("det_only", IDX_OSC_STOP, 8'h09);
    check("no_irq2", {sirq, ssel}, 2'h0);
    xact <= 1'h1;
    repeat (4) @(posedge clk);
    wrk(IDX_OSC_STOP, 8'h04);
    $display("test stop done");
  endtask

  task automatic t_wait;
    for (int i = 0; i < 2; i++) begin
      ifl <= i[0];
      wrk(IDX_WAIT_CTRL, 8'h01);
      repeat (10) @(posedge clk);
      check("in_wait", cen, 1'h0);
      check("clks_run", {ssel, lson}, 2'h3);
      pirq <= 1'h1;
      @(posedge clk);
      pirq <= 1'h0;
      #1 check("woke", cen, 1'h1);
      check("wake_pulse", {wsv, wrs}, i[0] ? 2'h2 : 2'h1);
      @(posedge clk);
      #1 check("pulse_one", {wsv, wrs}, 2'h0);
      rdk("wait_clr", IDX_WAIT_CTRL, 8'h00);
    end
    // Reset in mid-run also ends wait mode
    wrk(IDX_WAIT_CTRL, 8'h01);
    repeat (4) @(posedge clk);
    check("wait_again", cen, 1'h0);
    rst_b <= 1'h0;
    @(posedge clk);
    check("reset_wake", cen, 1'h1);
    rst_b <= 1'h1;
    @(posedge clk);
    rdk("wait_rst", IDX_WAIT_CTRL, 8'h00);
    rdk("osc_rst", IDX_OSC_STOP, 8'h04);
    check("rst_pins", {ssel, lson, hson, sirq}, 4'hc);
    $display("test wait done");
  endtask

  initial begin
    mismatches = 0;
    n_checks = 0;
    rst_b = 1'h0;
    {awv, wv, br, arv, rr, ifl, pirq, ack} = 8'h0;
    xact = 1'h1;
    awa = 8'h0;
    ara = 8'h0;
    wd = 32'h0;
    ws = 4'hf;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    t_reset();
    t_protect();
    t_hs();
    t_sysclk();
    t_stop();
    t_wait();
    test_done();
  end
endmodule
